// ==== load_shed_pkg.sv ====
// constants, register map and carrier types of the load shedding unit
package load_shed_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // byte offsets of the register words
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ_THR = 8'h04;
    localparam logic [7:0] OFS_FREQ_THR_ALT = 8'h08;
    localparam logic [7:0] OFS_DELAY = 8'h0c;
    localparam logic [7:0] OFS_DELAY_ALT = 8'h10;
    localparam logic [7:0] OFS_MIN_CURRENT = 8'h14;
    localparam logic [7:0] OFS_RELEASE_VOLT = 8'h18;
    localparam logic [7:0] OFS_TAN_ANGLE = 8'h1c;
    localparam logic [7:0] OFS_P_MIN = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;

    // control word fields
    localparam int CTRL_W = 5;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_METHOD_LSB = 1;
    localparam int CTRL_DIR_POS_BIT = 3;
    localparam int CTRL_EXT_ASSIGNED_BIT = 4;

    // live status word fields
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_TRIP_BIT = 1;
    localparam int STAT_DIR_BLOCK_BIT = 2;
    localparam int STAT_VOLT_OK_BIT = 3;
    localparam int STAT_ADAPT_BIT = 4;
    localparam int STAT_CURRENT_OK_BIT = 5;

    // sticky event fields
    localparam int IRQ_W = 3;
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_TRIP_BIT = 1;
    localparam int IRQ_CLEAR_BIT = 2;

    // synchronised pin positions
    localparam int PIN_W = 3;
    localparam int PIN_EXT_DIR = 0;
    localparam int PIN_DIR_BLOCK = 1;
    localparam int PIN_ADAPT = 2;

    // fixed point of the angle tangent
    localparam int TAN_FRAC_BITS = 8;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
    localparam logic [31:0] FREQ_THR_RESET = 32'h0000bf68;
    localparam logic [31:0] DELAY_RESET = 32'h00000000;
    localparam logic [31:0] MIN_CURRENT_RESET = 32'h00000000;
    localparam logic [31:0] RELEASE_VOLT_RESET = 32'h00000000;
    localparam logic [15:0] TAN_ANGLE_RESET = 16'h0100;
    localparam logic [31:0] P_MIN_RESET = 32'h00000000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // delay tick and its cycle count
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int SHED_TICK_MS = 1;
    localparam int CYCLES_PER_TICK = SYS_CLK_HZ / 1000 * SHED_TICK_MS;

    typedef enum logic [1:0] {
        METHOD_ANGLE,
        METHOD_POWER,
        METHOD_NONE
    } method_e;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [31:0] freq_thr;
        logic [31:0] freq_thr_alt;
        logic [31:0] delay;
        logic [31:0] delay_alt;
        logic [31:0] min_current;
        logic [31:0] release_volt;
        logic [15:0] tan_angle;
        logic [31:0] p_min;
    } cfg_s;

    // measured quantities, same clock, unsigned except powers
    typedef struct packed {
        logic [31:0] freq_mhz;
        logic [31:0] volt_ll;
        logic [31:0] i1;
        logic signed [31:0] p1;
        logic signed [31:0] q1;
    } meas_s;

    typedef struct packed {
        logic [31:0] prescale;
        logic [31:0] ticks;
        logic expired;
    } timer_state_s;

endpackage

// ==== shed_delay_timer.sv ====
// trip delay timer counting whole ticks while the alarm stands
`timescale 1ns/1ps
module shed_delay_timer #(
    parameter int CYCLES_PER_TICK = load_shed_pkg::CYCLES_PER_TICK
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [31:0] delay_ticks,
    output logic expired
);
    localparam logic [31:0] LAST = 32'(CYCLES_PER_TICK - 1);

    load_shed_pkg::timer_state_s s;
    load_shed_pkg::timer_state_s next_s;

    always_comb begin
        next_s = s;
        if (!run) begin
            // alarm gone: restart from zero, never trip early
            next_s = '0;
        end else begin
            if (s.prescale == LAST) begin
                next_s.prescale = 32'h0;
                if (!s.expired) begin
                    next_s.ticks = s.ticks + 32'h1;
                end
            end else begin
                next_s.prescale = s.prescale + 32'h1;
            end
            next_s.expired = s.ticks >= delay_ticks;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign expired = s.expired;
endmodule

// ==== load_shed_unit.sv ====
// under frequency load shedding unit with wishbone registers
//
// How it works
// - direction setting can reverse active power sign
// - setting negative for load, positive for generator
// - direction uses positive sequence active power
// - low positive sequence current suppresses direction
// - release only at or above release voltage
// - selector picks angle, power or no direction
// - angle method blocks inside power angle area
// - power method blocks above minimum power
// - no direction: frequency alone starts shedding
// - no direction: external input controls blocking
// - blocking input disables direction evaluation
// - alarm when frequency below threshold and released
// - alarm starts delay timer, trip on expiry
// - activation input selects adaptive threshold and delay
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module load_shed_unit #(
    parameter int CYCLES_PER_TICK = load_shed_pkg::CYCLES_PER_TICK
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [load_shed_pkg::ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [load_shed_pkg::DATA_W-1:0] wb_dat_w,
    output logic [load_shed_pkg::DATA_W-1:0] wb_dat_r,
    output logic wb_ack,
    input wire load_shed_pkg::meas_s meas,
    input wire logic external_direction_input,
    input wire logic direction_block_input,
    input wire logic adaptive_activate,
    output logic shed_trip,
    output logic shed_alarm,
    output logic irq
);
    typedef struct packed {
        load_shed_pkg::cfg_s cfg;
        logic [load_shed_pkg::PIN_W-1:0] pin_meta;
        logic [load_shed_pkg::PIN_W-1:0] pin_sync;
        logic [load_shed_pkg::IRQ_W-1:0] irq_status;
        logic [load_shed_pkg::IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic ack;
        logic alarm;
        logic trip;
        logic dir_block;
        logic volt_ok;
        logic current_ok;
        logic irq;
    } unit_state_s;

    localparam load_shed_pkg::cfg_s CFG_RESET = '{
        ctrl: load_shed_pkg::CTRL_RESET,
        freq_thr: load_shed_pkg::FREQ_THR_RESET,
        freq_thr_alt: load_shed_pkg::FREQ_THR_RESET,
        delay: load_shed_pkg::DELAY_RESET,
        delay_alt: load_shed_pkg::DELAY_RESET,
        min_current: load_shed_pkg::MIN_CURRENT_RESET,
        release_volt: load_shed_pkg::RELEASE_VOLT_RESET,
        tan_angle: load_shed_pkg::TAN_ANGLE_RESET,
        p_min: load_shed_pkg::P_MIN_RESET
    };

    unit_state_s s;
    unit_state_s next_s;
    logic timer_expired;
    logic [31:0] delay_sel;

    // byte lane merge used by every writable word
    function automatic logic [31:0] merge_sel(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction

    assign delay_sel = s.pin_sync[load_shed_pkg::PIN_ADAPT] ?
        s.cfg.delay_alt : s.cfg.delay;

    shed_delay_timer #(
        .CYCLES_PER_TICK(CYCLES_PER_TICK)
    ) delay_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(s.alarm),
        .delay_ticks(delay_sel),
        .expired(timer_expired)
    );

    always_comb begin
        logic signed [31:0] p_eff;
        logic [31:0] q_abs;
        logic [47:0] q_scaled;
        logic [47:0] p_scaled;
        logic [31:0] thr;
        logic angle_block;
        logic power_block;
        logic dir_eval;
        logic ext_block;
        logic f_low;
        logic wr;
        logic rd;
        logic [31:0] wdata;
        logic [load_shed_pkg::IRQ_W-1:0] ev;
        logic [load_shed_pkg::IRQ_W-1:0] clr;
        logic [load_shed_pkg::IRQ_W-1:0] stat;
        load_shed_pkg::method_e method;

        next_s = s;
        p_eff = 32'sh0;
        q_abs = 32'h0;
        q_scaled = 48'h0;
        p_scaled = 48'h0;
        thr = 32'h0;
        angle_block = 1'b0;
        power_block = 1'b0;
        dir_eval = 1'b0;
        ext_block = 1'b0;
        f_low = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 32'h0;
        ev = '0;
        clr = '0;
        stat = '0;
        method = load_shed_pkg::METHOD_NONE;

        // pins pass two flops before use
        next_s.pin_meta = {adaptive_activate, direction_block_input,
            external_direction_input};
        next_s.pin_sync = s.pin_meta;

        // blocking area is defined in the generator arrow frame
        p_eff = s.cfg.ctrl[load_shed_pkg::CTRL_DIR_POS_BIT] ?
            meas.p1 : -meas.p1;
        q_abs = abs32(meas.q1);

        // inside the angle area: p > 0 and |q| <= p * tan(angle)
        q_scaled = {8'h0, q_abs, 8'h0};
        p_scaled = 48'(32'(p_eff)) * 48'(s.cfg.tan_angle);
        angle_block = !p_eff[31] && (p_eff != 32'sh0) &&
            (q_scaled <= p_scaled);
        power_block = p_eff > $signed(s.cfg.p_min);

        next_s.current_ok = meas.i1 >= s.cfg.min_current;
        // low current makes the power sign meaningless
        dir_eval = next_s.current_ok &&
            !s.pin_sync[load_shed_pkg::PIN_DIR_BLOCK];
        ext_block = s.cfg.ctrl[load_shed_pkg::CTRL_EXT_ASSIGNED_BIT] &&
            !s.pin_sync[load_shed_pkg::PIN_DIR_BLOCK] &&
            s.pin_sync[load_shed_pkg::PIN_EXT_DIR];

        // code 3 is illegal and never blocks, not even on the external input
        method = load_shed_pkg::method_e'(s.cfg.ctrl[
            load_shed_pkg::CTRL_METHOD_LSB +: 2]);
        unique case (method)
            load_shed_pkg::METHOD_ANGLE: begin
                next_s.dir_block = dir_eval && angle_block;
            end
            load_shed_pkg::METHOD_POWER: begin
                next_s.dir_block = dir_eval && power_block;
            end
            load_shed_pkg::METHOD_NONE: begin
                next_s.dir_block = ext_block;
            end
            default: begin
                next_s.dir_block = 1'b0;
            end
        endcase

        thr = s.pin_sync[load_shed_pkg::PIN_ADAPT] ?
            s.cfg.freq_thr_alt : s.cfg.freq_thr;
        f_low = meas.freq_mhz < thr;
        next_s.volt_ok = meas.volt_ll >= s.cfg.release_volt;
        next_s.alarm = s.cfg.ctrl[load_shed_pkg::CTRL_EN_BIT] && f_low &&
            next_s.volt_ok && !next_s.dir_block;
        next_s.trip = timer_expired && s.alarm;

        // wishbone: one wait state, ack drops the cycle after it rose
        // write lands on the edge where the master samples ack
        wr = wb_cyc && wb_stb && wb_we && s.ack;
        rd = wb_cyc && wb_stb && !wb_we && !s.ack;
        next_s.ack = wb_cyc && wb_stb && !s.ack;
        if (wr) begin
            unique case (wb_adr)
                load_shed_pkg::OFS_CTRL: begin
                    wdata = merge_sel(32'(s.cfg.ctrl), wb_dat_w, wb_sel);
                    next_s.cfg.ctrl = wdata[load_shed_pkg::CTRL_W-1:0];
                end
                load_shed_pkg::OFS_FREQ_THR: begin
                    next_s.cfg.freq_thr =
                        merge_sel(s.cfg.freq_thr, wb_dat_w, wb_sel);
                end
                load_shed_pkg::OFS_FREQ_THR_ALT: begin
                    next_s.cfg.freq_thr_alt =
                        merge_sel(s.cfg.freq_thr_alt, wb_dat_w, wb_sel);
                end
                load_shed_pkg::OFS_DELAY: begin
                    next_s.cfg.delay =
                        merge_sel(s.cfg.delay, wb_dat_w, wb_sel);
                end
                load_shed_pkg::OFS_DELAY_ALT: begin
                    next_s.cfg.delay_alt =
                        merge_sel(s.cfg.delay_alt, wb_dat_w, wb_sel);
                end
                load_shed_pkg::OFS_MIN_CURRENT: begin
                    next_s.cfg.min_current =
                        merge_sel(s.cfg.min_current, wb_dat_w, wb_sel);
                end
                load_shed_pkg::OFS_RELEASE_VOLT: begin
                    next_s.cfg.release_volt =
                        merge_sel(s.cfg.release_volt, wb_dat_w, wb_sel);
                end
                load_shed_pkg::OFS_TAN_ANGLE: begin
                    wdata = merge_sel(32'(s.cfg.tan_angle), wb_dat_w, wb_sel);
                    next_s.cfg.tan_angle = wdata[15:0];
                end
                load_shed_pkg::OFS_P_MIN: begin
                    next_s.cfg.p_min =
                        merge_sel(s.cfg.p_min, wb_dat_w, wb_sel);
                end
                load_shed_pkg::OFS_IRQ_STATUS: begin
                    wdata = merge_sel(32'h0, wb_dat_w, wb_sel);
                    clr = wdata[load_shed_pkg::IRQ_W-1:0];
                end
                load_shed_pkg::OFS_IRQ_MASK: begin
                    wdata = merge_sel(32'(s.irq_mask), wb_dat_w, wb_sel);
                    next_s.irq_mask = wdata[load_shed_pkg::IRQ_W-1:0];
                end
                default: begin
                    wdata = 32'h0;
                end
            endcase
        end

        next_s.rdata = 32'h0;
        if (rd) begin
            unique case (wb_adr)
                load_shed_pkg::OFS_CTRL: next_s.rdata = 32'(s.cfg.ctrl);
                load_shed_pkg::OFS_FREQ_THR: next_s.rdata = s.cfg.freq_thr;
                load_shed_pkg::OFS_FREQ_THR_ALT: begin
                    next_s.rdata = s.cfg.freq_thr_alt;
                end
                load_shed_pkg::OFS_DELAY: next_s.rdata = s.cfg.delay;
                load_shed_pkg::OFS_DELAY_ALT: next_s.rdata = s.cfg.delay_alt;
                load_shed_pkg::OFS_MIN_CURRENT: begin
                    next_s.rdata = s.cfg.min_current;
                end
                load_shed_pkg::OFS_RELEASE_VOLT: begin
                    next_s.rdata = s.cfg.release_volt;
                end
                load_shed_pkg::OFS_TAN_ANGLE: begin
                    next_s.rdata = 32'(s.cfg.tan_angle);
                end
                load_shed_pkg::OFS_P_MIN: next_s.rdata = s.cfg.p_min;
                load_shed_pkg::OFS_STATUS: begin
                    next_s.rdata[load_shed_pkg::STAT_ALARM_BIT] = s.alarm;
                    next_s.rdata[load_shed_pkg::STAT_TRIP_BIT] = s.trip;
                    next_s.rdata[load_shed_pkg::STAT_DIR_BLOCK_BIT] =
                        s.dir_block;
                    next_s.rdata[load_shed_pkg::STAT_VOLT_OK_BIT] = s.volt_ok;
                    next_s.rdata[load_shed_pkg::STAT_ADAPT_BIT] =
                        s.pin_sync[load_shed_pkg::PIN_ADAPT];
                    next_s.rdata[load_shed_pkg::STAT_CURRENT_OK_BIT] =
                        s.current_ok;
                end
                load_shed_pkg::OFS_IRQ_STATUS: begin
                    next_s.rdata = 32'(s.irq_status);
                end
                load_shed_pkg::OFS_IRQ_MASK: next_s.rdata = 32'(s.irq_mask);
                default: next_s.rdata = 32'h0;
            endcase
        end

        // a new event beats a clear in the same cycle
        ev[load_shed_pkg::IRQ_ALARM_BIT] = next_s.alarm && !s.alarm;
        ev[load_shed_pkg::IRQ_TRIP_BIT] = next_s.trip && !s.trip;
        ev[load_shed_pkg::IRQ_CLEAR_BIT] = !next_s.alarm && s.alarm;
        stat = (s.irq_status & ~clr) | ev;
        next_s.irq_status = stat;
        next_s.irq = |(stat & next_s.irq_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '{
                cfg: CFG_RESET,
                irq_status: load_shed_pkg::IRQ_RESET,
                irq_mask: load_shed_pkg::IRQ_RESET,
                default: '0
            };
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_r = s.rdata;
    assign wb_ack = s.ack;
    assign shed_trip = s.trip;
    assign shed_alarm = s.alarm;
    assign irq = s.irq;
endmodule

// ==== load_shed_chk.sv ====
// port assertions for the load shedding unit
`timescale 1ns/1ps
module load_shed_chk #(
    parameter int CYCLES_PER_TICK = load_shed_pkg::CYCLES_PER_TICK
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [load_shed_pkg::ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [load_shed_pkg::DATA_W-1:0] wb_dat_w,
    input wire logic [load_shed_pkg::DATA_W-1:0] wb_dat_r,
    input wire logic wb_ack,
    input wire load_shed_pkg::meas_s meas,
    input wire logic external_direction_input,
    input wire logic direction_block_input,
    input wire logic adaptive_activate,
    input wire logic shed_trip,
    input wire logic shed_alarm,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic [2:0] pins;
    // pins pass two sync flops, so settling needs four quiet cycles
    assign pins = {external_direction_input, direction_block_input,
        adaptive_activate};
    chk_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");
    chk_ack_wait: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("ack missing one cycle after request");
    chk_ack_cause: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
        else $error("ack without request");
    chk_rdat_idle: assert property (!wb_ack |-> wb_dat_r == '0)
        else $error("read data not zero outside ack");
    chk_wr_rdat: assert property (wb_ack && wb_we |-> wb_dat_r == '0)
        else $error("read data not zero on write ack");
    chk_unmapped_rd: assert property (
        wb_ack && !wb_we && wb_adr > load_shed_pkg::OFS_IRQ_MASK
        |-> wb_dat_r == '0)
        else $error("unmapped address read not zero");
    chk_alarm_settled: assert property (
        (!wb_cyc && $stable(meas) && $stable(pins)) [*4]
        |-> $stable(shed_alarm))
        else $error("alarm moved with quiet inputs");
    chk_trip_cause: assert property (
        $rose(shed_trip) |-> $past(shed_alarm))
        else $error("trip rose without alarm");
    chk_timer_fresh: assert property (
        $rose(shed_alarm) |-> !shed_trip)
        else $error("trip already high at new alarm");
    chk_trip_idle: assert property (
        !shed_alarm [*2] |-> !shed_trip)
        else $error("trip stays after alarm cleared");
    chk_irq_settled: assert property (
        (!wb_cyc && $stable(shed_alarm) && $stable(shed_trip)) [*3]
        |-> $stable(irq))
        else $error("irq moved without event or access");
endmodule

bind load_shed_unit load_shed_chk #(
    .CYCLES_PER_TICK(CYCLES_PER_TICK)
) load_shed_chk_inst (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .meas(meas), .external_direction_input(external_direction_input),
    .direction_block_input(direction_block_input),
    .adaptive_activate(adaptive_activate), .shed_trip(shed_trip),
    .shed_alarm(shed_alarm), .irq(irq)
);

// ==== meas_front.sv ====
// measurement front end and breaker model around the unit
`timescale 1ns/1ps
module meas_front (
    input wire logic sys_clk,
    input wire load_shed_pkg::meas_s plant,
    input wire logic shed_trip,
    output load_shed_pkg::meas_s meas,
    output logic [7:0] trip_count
);
    logic trip_seen;
    initial begin
        meas = '0;
        trip_count = 8'h00;
        trip_seen = 1'b0;
    end
    // one fresh sample per clock, current and powers as positive sequence values
    always @(posedge sys_clk) begin
        meas <= plant;
        trip_seen <= shed_trip;
        if (shed_trip && !trip_seen) begin
            trip_count <= trip_count + 8'h01;
        end
    end
endmodule

// ==== testbench.sv ====
// self-checking bench for the load shedding unit
`timescale 1ns/1ps
module testbench;
    localparam int TICK = 4;
    logic sys_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, irq;
    logic ext_dir, dir_blk, adapt, shed_trip, shed_alarm;
    logic [7:0] wb_adr, trips, t0;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    load_shed_pkg::meas_s plant, meas;
    int fail_count, cmp_count, cyc_count, n;

    load_shed_unit #(.CYCLES_PER_TICK(TICK)) load_shed_unit_inst (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .meas(meas), .external_direction_input(ext_dir),
        .direction_block_input(dir_blk), .adaptive_activate(adapt),
        .shed_trip(shed_trip), .shed_alarm(shed_alarm), .irq(irq));
    meas_front meas_front_inst (.sys_clk(sys_clk), .plant(plant),
        .shed_trip(shed_trip), .meas(meas), .trip_count(trips));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // run length is a few hundred cycles; this only cuts a hang
    always @(posedge sys_clk) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            fail_count++;
            $display("Error %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check1(input logic s, input logic e);
        check({31'h0, s}, {31'h0, e});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic bus(input logic we, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        do @(posedge sys_clk); while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        check(rd, x);
    endtask
    // cycles from alarm rise to trip rise must fall in lo..hi
    task automatic trip_after(input int lo, input int hi);
        n = 0;
        while (shed_alarm !== 1'b1) @(posedge sys_clk);
        while (shed_trip !== 1'b1) begin
            @(posedge sys_clk);
            n++;
        end
        check1(n >= lo && n <= hi, 1'b1);
    endtask
    task automatic dcase(input logic [4:0] c, input logic [31:0] p,
            input logic [31:0] q, input logic [31:0] i, input logic e,
            input logic b, input logic x);
        wr(load_shed_pkg::OFS_CTRL, {27'h0, c});
        plant.p1 <= p;
        plant.q1 <= q;
        plant.i1 <= i;
        ext_dir <= e;
        dir_blk <= b;
        tick(6);
        check1(shed_alarm, x);
    endtask

    initial begin
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we, ext_dir, dir_blk, adapt} = 6'h00;
        wb_adr = 8'h00;
        wb_sel = 4'hf;
        wb_dat_w = 32'h0;
        plant = '0;
        plant.freq_mhz = 32'h0000c350;
        plant.volt_ll = 32'h00000064;
        plant.i1 = 32'h0000000a;
        plant.p1 = 32'hfffffc18;
        {fail_count, cmp_count, cyc_count} = '0;
        tick(3);
        rst <= 1'b0;
        rdc(load_shed_pkg::OFS_CTRL, 32'h0);
        rdc(load_shed_pkg::OFS_FREQ_THR, load_shed_pkg::FREQ_THR_RESET);
        rdc(load_shed_pkg::OFS_TAN_ANGLE, 32'h00000100);
        wr(load_shed_pkg::OFS_STATUS, 32'hffffffff);
        rdc(load_shed_pkg::OFS_STATUS, 32'h0000002c);
        wr(8'h30, 32'hffffffff);
        rdc(8'h30, 32'h0);
        $display("test registers done");
        wr(load_shed_pkg::OFS_RELEASE_VOLT, 32'h00000064);
        wr(load_shed_pkg::OFS_DELAY, 32'h00000005);
        wr(load_shed_pkg::OFS_CTRL, 32'h00000005);
        plant.volt_ll <= 32'h00000063;
        plant.freq_mhz <= 32'h0000bb80;
        tick(8);
        check1(shed_alarm, 1'b0);
        plant.volt_ll <= 32'h00000064;
        trip_after(5*TICK + 1, 5*TICK + 4);
        tick(2);
        check1(irq, 1'b0);
        wr(load_shed_pkg::OFS_IRQ_MASK, 32'h00000007);
        tick(2);
        check1(irq, 1'b1);
        rdc(load_shed_pkg::OFS_IRQ_STATUS, 32'h00000003);
        wr(load_shed_pkg::OFS_IRQ_STATUS, 32'h00000003);
        tick(2);
        check1(irq, 1'b0);
        $display("test trip done");
        plant.freq_mhz <= 32'h0000c350;
        tick(4);
        check1(shed_trip, 1'b0);
        wr(load_shed_pkg::OFS_IRQ_STATUS, 32'h00000007);
        t0 = trips;
        plant.freq_mhz <= 32'h0000bb80;
        tick(10);
        plant.freq_mhz <= 32'h0000c350;
        tick(30);
        check({24'h0, trips}, {24'h0, t0});
        plant.freq_mhz <= 32'h0000bb80;
        trip_after(5 * TICK + 1, 5 * TICK + 4);
        plant.freq_mhz <= 32'h0000c350;
        tick(4);
        check1(shed_trip, 1'b0);
        $display("test abort done");
        wr(load_shed_pkg::OFS_FREQ_THR_ALT, 32'h0000b798);
        wr(load_shed_pkg::OFS_DELAY_ALT, 32'h00000001);
        adapt <= 1'b1;
        tick(4);
        plant.freq_mhz <= 32'h0000bb80;
        tick(8);
        check1(shed_alarm, 1'b0);
        plant.freq_mhz <= 32'h0000b3b0;
        trip_after(TICK + 1, TICK + 4);
        rdc(load_shed_pkg::OFS_CTRL, 32'h00000005);
        adapt <= 1'b0;
        plant.freq_mhz <= 32'h0000bb80;
        $display("test adaptive done");
        wr(load_shed_pkg::OFS_DELAY, 32'h000003e8);
        wr(load_shed_pkg::OFS_MIN_CURRENT, 32'h00000005);
        wr(load_shed_pkg::OFS_P_MIN, 32'h000001f4);
        dcase(5'h01, 32'hfffffc18, 0, 32'ha, 0, 0, 0);
        dcase(5'h01, 32'h000003e8, 0, 32'ha, 0, 0, 1);
        dcase(5'h01, 32'hfffffc18, 32'h7d0, 32'ha, 0, 0, 1);
        dcase(5'h09, 32'h000003e8, 0, 32'ha, 0, 0, 0);
        dcase(5'h01, 32'hfffffc18, 0, 32'h4, 0, 0, 1);
        dcase(5'h01, 32'hfffffc18, 0, 32'ha, 0, 1, 1);
        dcase(5'h03, 32'hfffffc18, 0, 32'ha, 0, 0, 0);
        dcase(5'h03, 32'hfffffe0c, 0, 32'ha, 0, 0, 1);
        dcase(5'h05, 32'hfffffc18, 0, 32'ha, 1, 0, 1);
        dcase(5'h15, 32'h000003e8, 0, 32'ha, 1, 0, 0);
        dcase(5'h15, 32'hfffffc18, 0, 32'ha, 0, 0, 1);
        dcase(5'h15, 32'hfffffc18, 0, 32'ha, 1, 1, 1);
        dcase(5'h17, 32'hfffffc18, 0, 32'ha, 1, 0, 1);
        $display("test direction done");
        end_sim();
    end
endmodule
